// File: psu_status_pkg.sv
// Constants and carrier types for the supply status and alert bank
`default_nettype none
package psu_status_pkg;
  // Command codes
  localparam logic [7:0] CMD_PAGE        = 8'h00;
  localparam logic [7:0] CMD_OUTPUT_ON_COMMAND   = 8'h01;
  localparam logic [7:0] CMD_FAULT_CLEAR = 8'h03;
  localparam logic [7:0] CMD_ALERT_MASK  = 8'h1b;
  localparam logic [7:0] CMD_STAT_WORD   = 8'h79;
  localparam logic [7:0] CMD_STAT_VOUT   = 8'h7a;
  localparam logic [7:0] CMD_STAT_IOUT   = 8'h7b;
  localparam logic [7:0] CMD_STAT_INPUT  = 8'h7c;
  localparam logic [7:0] CMD_STAT_TEMP   = 8'h7d;
  localparam logic [7:0] CMD_STAT_CML    = 8'h7e;
  localparam logic [7:0] CMD_STAT_FAN    = 8'h81;
  localparam logic [7:0] CMD_TEMP_INLET  = 8'h8d;
  localparam logic [7:0] CMD_TEMP_RECT   = 8'h8e;
  localparam logic [7:0] CMD_TEMP_PFC    = 8'h8f;
  // Page values and instance indices
  localparam logic [7:0] PAGE_BMC = 8'h00;
  localparam logic [7:0] PAGE_ME  = 8'h01;
  localparam logic [7:0] PAGE_ALL = 8'hff;
  localparam int NUM_INST    = 3;
  localparam int INST_DIRECT = 0;
  localparam int INST_BMC    = 1;
  localparam int INST_ME     = 2;
  // Bit positions
  localparam int OP_ON_BIT   = 7;
  localparam int W_OFF       = 6;
  localparam int W_IOUT_OC   = 4;
  localparam int W_VIN_UV    = 3;
  localparam int W_TEMP      = 2;
  localparam int W_CML       = 1;
  localparam int W_VOUT      = 15;
  localparam int W_IOUT      = 14;
  localparam int W_INPUT     = 13;
  localparam int W_FANS      = 10;
  localparam int VOUT_OV     = 7;
  localparam int VOUT_UV     = 4;
  localparam int IOUT_OCF    = 7;
  localparam int IOUT_OCW    = 5;
  localparam int POUT_OPF    = 1;
  localparam int POUT_OPW    = 0;
  localparam int IN_UVW      = 5;
  localparam int IN_UVF      = 4;
  localparam int IN_OFF_LOW  = 3;
  localparam int IN_IIN_OCW  = 1;
  localparam int IN_PIN_OPW  = 0;
  localparam int T_OTF       = 7;
  localparam int T_OTW       = 6;
  localparam int CML_BADCMD  = 7;
  localparam int CML_BADDATA = 6;
  localparam int CML_PEC     = 5;
  localparam int FAN_FAULT   = 7;
  localparam int FAN_WARN    = 5;
  // Status register group, one per instance
  typedef struct packed {
    logic [7:0] vout;
    logic [7:0] iout;
    logic [7:0] inp;
    logic [7:0] temp;
    logic [7:0] comm_fault_summary;
    logic [7:0] fan;
  } stat_s;
  // Reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] OP_RST   = 8'h80;
  localparam stat_s MASK_RST    = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  localparam stat_s MASK_ME_RST = '{8'hff, 8'hdf, 8'hef, 8'hbf, 8'hff, 8'hff};
  // Bits whose state turns the output off
  localparam stat_s OFF_BITS    = '{8'h90, 8'h82, 8'h08, 8'h80, 8'h00, 8'h80};
  // Bus transaction and its reply
  typedef struct packed {
    logic [7:0]  cmd;
    logic        paged;
    logic [7:0]  page;
    logic        write;
    logic [15:0] wdata;
    logic        pec_err;
  } xact_s;
  typedef struct packed {
    logic [15:0] rdata;
    logic        refused;
  } reply_s;
  // Raw power stage events
  typedef struct packed {
    logic vout_ov;
    logic vout_uv;
    logic output_overcurrent_fault;
    logic iout_oc_warn;
    logic output_overpower_fault;
    logic pout_op_warn;
    logic vin_uv_warn;
    logic input_undervoltage_fault;
    logic unit_off_low_in;
    logic iin_oc_warn;
    logic pin_op_warn;
    logic overtemperature_fault;
    logic ot_warn;
  } event_s;
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_REPLY} core_state_e;
endpackage
`default_nettype wire

// File: temp_store.sv
// Small word store for temperature readings, registered read data
`default_nettype none
module temp_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock
  input  wire logic                     clock,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output var  logic [WIDTH-1:0]         rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  // No reset: readings are garbage until the first sample lands
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
    rd_data <= mem_r[rd_addr];
  end
endmodule
`default_nettype wire

// File: psu_status_alert_bank.sv
// Status, alert mask and output control bank of the managed supply
`default_nettype none
module psu_status_alert_bank
  import psu_status_pkg::*;
#(
  parameter int NUM_FANS = 1
) (
  // Core clock and reset
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  // Serial link side, on the link clock
  input  wire logic                   link_clk,
  input  wire logic                   xact_valid,
  input  wire psu_status_pkg::xact_s  xact,
  output var  logic                   link_busy,
  output var  logic                   reply_valid,
  output var  psu_status_pkg::reply_s reply,
  // Power stage events and control pin, asynchronous
  input  wire psu_status_pkg::event_s events,
  input  wire logic [NUM_FANS-1:0]    fan_fault,
  input  wire logic [NUM_FANS-1:0]    fan_warn,
  input  wire logic                   ctrl_pin,
  // Temperature samples, core clock
  input  wire logic                   temp_wr_valid,
  input  wire logic [1:0]             temp_wr_sel,
  input  wire logic [15:0]            temp_wr_value,
  // Outputs
  output var  logic                   output_on,
  output var  logic                   smbalert_out,
  output var  logic                   smbalert_oe
);
  import psu_status_pkg::*;

  localparam int RAW_W = $bits(event_s) + 2 * NUM_FANS + 1;

  // Summary word of one instance
  function automatic logic [15:0] summary(stat_s s, logic [7:0] fan,
                                          logic on);
    logic [15:0] w;
    w = '0;
    w[W_OFF]     = ~on;
    w[W_IOUT_OC] = s.iout[IOUT_OCF];
    w[W_VIN_UV]  = s.inp[IN_UVF];
    w[W_TEMP]    = |s.temp;
    w[W_CML]     = |s.comm_fault_summary;
    w[W_VOUT]    = |s.vout;
    w[W_IOUT]    = |s.iout;
    w[W_INPUT]   = |s.inp;
    w[W_FANS]    = |fan;
    return w;
  endfunction

  // Byte of a status group picked by command code
  function automatic logic [7:0] pick(stat_s s, logic [7:0] code);
    case (code)
      CMD_STAT_VOUT:  pick = s.vout;
      CMD_STAT_IOUT:  pick = s.iout;
      CMD_STAT_INPUT: pick = s.inp;
      CMD_STAT_TEMP:  pick = s.temp;
      CMD_STAT_CML:   pick = s.comm_fault_summary;
      CMD_STAT_FAN:   pick = s.fan;
      default:        pick = 8'h00;
    endcase
  endfunction

  // Group with one byte placed by command code
  function automatic stat_s place(logic [7:0] code, logic [7:0] v);
    stat_s s;
    s = '0;
    case (code)
      CMD_STAT_VOUT:  s.vout = v;
      CMD_STAT_IOUT:  s.iout = v;
      CMD_STAT_INPUT: s.inp  = v;
      CMD_STAT_TEMP:  s.temp = v;
      CMD_STAT_CML:   s.comm_fault_summary  = v;
      CMD_STAT_FAN:   s.fan  = v;
      default:        s = '0;
    endcase
    return s;
  endfunction

  // ---------------- Link domain ----------------
  xact_s  hold_r;
  logic   req_tgl_r, busy_r, ack_s1_r, ack_s2_r, ack_seen_r;
  logic   ack_tgl_r;
  reply_s reply_hold_r;
  logic   link_take;

  assign link_take = xact_valid && !busy_r;

  // Hold the transaction steady until the core answers
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_r      <= '0;
      req_tgl_r   <= 1'b0;
      busy_r      <= 1'b0;
      ack_s1_r    <= 1'b0;
      ack_s2_r    <= 1'b0;
      ack_seen_r  <= 1'b0;
      reply_valid <= 1'b0;
      reply       <= '0;
    end else begin
      ack_s1_r    <= ack_tgl_r;
      ack_s2_r    <= ack_s1_r;
      reply_valid <= 1'b0;
      if (link_take) begin
        hold_r    <= xact;
        req_tgl_r <= ~req_tgl_r;
        busy_r    <= 1'b1;
      end else if (ack_s2_r != ack_seen_r) begin
        // Reply word was parked in the toggle's cycle, so after the sync it is stable
        ack_seen_r  <= ack_s2_r;
        busy_r      <= 1'b0;
        reply_valid <= 1'b1;
        reply       <= reply_hold_r;
      end
    end
  end
  assign link_busy = busy_r;

  // ---------------- Core domain ----------------
  logic [RAW_W-1:0] raw_s1_r, raw_s2_r;
  logic             req_s1_r, req_s2_r, req_s3_r;
  event_s           ev;
  logic [NUM_FANS-1:0] ff_q, fw_q;
  logic             ctrl_q, new_req;

  // Two flops on every asynchronous input before use
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      raw_s1_r <= '0;
      raw_s2_r <= '0;
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
    end else begin
      raw_s1_r <= {events, fan_fault, fan_warn, ctrl_pin};
      raw_s2_r <= raw_s1_r;
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end
  assign {ev, ff_q, fw_q, ctrl_q} = raw_s2_r;
  assign new_req = req_s2_r ^ req_s3_r;

  core_state_e state_r, state_nxt;
  stat_s       stat_r [NUM_INST];
  stat_s       stat_nxt [NUM_INST];
  stat_s       mask_r [NUM_INST];
  stat_s       mask_nxt [NUM_INST];
  stat_s       clr_vec [NUM_INST];
  stat_s       ev_stat;
  logic [7:0]  page_r, page_nxt, op_r, op_nxt;
  logic        on_nxt, alert_any, inst_ok, fc_all;
  int          inst;
  logic [2:0]  cml_set;
  reply_s      rep_nxt;
  logic        ack_nxt;
  logic [15:0] rd_exec_r, rd_exec_nxt;
  logic        ref_exec_r, ref_exec_nxt, temp_cmd_r, temp_cmd_nxt;
  logic [15:0] temp_rd;
  logic [1:0]  temp_addr;
  logic [7:0]  keep_iout;

  temp_store #(.WIDTH(16), .DEPTH(4)) u_temps (
    .clock   (clock),
    .wr_en   (temp_wr_valid),
    .wr_addr (temp_wr_sel),
    .wr_data (temp_wr_value),
    .rd_addr (temp_addr),
    .rd_data (temp_rd)
  );
  assign temp_addr = hold_r.cmd[1:0] - CMD_TEMP_INLET[1:0];

  // Event pattern shared by every instance
  always_comb begin
    ev_stat                    = '0;
    ev_stat.vout[VOUT_OV]      = ev.vout_ov;
    ev_stat.vout[VOUT_UV]      = ev.vout_uv;
    ev_stat.iout[IOUT_OCF]     = ev.output_overcurrent_fault;
    ev_stat.iout[IOUT_OCW]     = ev.iout_oc_warn;
    ev_stat.iout[POUT_OPF]     = ev.output_overpower_fault;
    ev_stat.iout[POUT_OPW]     = ev.pout_op_warn;
    ev_stat.inp[IN_UVW]        = ev.vin_uv_warn;
    // Any sampled low input latches, even if the unit rides through
    ev_stat.inp[IN_UVF]        = ev.input_undervoltage_fault;
    ev_stat.inp[IN_OFF_LOW]    = ev.unit_off_low_in;
    ev_stat.inp[IN_IIN_OCW]    = ev.iin_oc_warn;
    ev_stat.inp[IN_PIN_OPW]    = ev.pin_op_warn;
    ev_stat.temp[T_OTF]        = ev.overtemperature_fault;
    ev_stat.temp[T_OTW]        = ev.ot_warn;
    ev_stat.fan[FAN_FAULT]     = |ff_q;
    ev_stat.fan[FAN_WARN]      = |fw_q;
    ev_stat.comm_fault_summary[CML_BADCMD]    = cml_set[2];
    ev_stat.comm_fault_summary[CML_BADDATA]   = cml_set[1];
    ev_stat.comm_fault_summary[CML_PEC]       = cml_set[0];
  end

  // Decode and execute one transaction
  always_comb begin
    state_nxt    = state_r;
    page_nxt     = page_r;
    op_nxt       = op_r;
    rd_exec_nxt  = rd_exec_r;
    ref_exec_nxt = ref_exec_r;
    temp_cmd_nxt = temp_cmd_r;
    rep_nxt      = reply_hold_r;
    ack_nxt      = ack_tgl_r;
    cml_set      = 3'b000;
    fc_all       = 1'b0;
    inst_ok      = 1'b1;
    inst         = INST_DIRECT;
    for (int i = 0; i < NUM_INST; i++) begin
      clr_vec[i]  = '0;
      mask_nxt[i] = mask_r[i];
    end
    if (hold_r.paged) begin
      // Paged calls reach the two controller copies
      inst_ok = (hold_r.page == PAGE_BMC) || (hold_r.page == PAGE_ME);
      inst    = (hold_r.page == PAGE_ME) ? INST_ME : INST_BMC;
    end
    case (state_r)
      ST_IDLE: begin
        if (new_req) begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_nxt    = ST_REPLY;
        rd_exec_nxt  = '0;
        ref_exec_nxt = 1'b0;
        temp_cmd_nxt = 1'b0;
        cml_set[0]   = hold_r.pec_err;
        if (hold_r.pec_err) begin
          ref_exec_nxt = 1'b1;
        end else if (!inst_ok) begin
          ref_exec_nxt = 1'b1;
          cml_set[1]   = 1'b1;
        end else begin
          case (hold_r.cmd)
            CMD_PAGE: begin
              if (hold_r.write) page_nxt = hold_r.wdata[7:0];
              rd_exec_nxt = {8'h00, page_r};
            end
            CMD_OUTPUT_ON_COMMAND: begin
              if (hold_r.write) op_nxt = hold_r.wdata[7:0];
              rd_exec_nxt = {8'h00, op_r};
            end
            CMD_FAULT_CLEAR: begin
              // Page FFh widens the clear to every instance
              fc_all = (page_r == PAGE_ALL);
              for (int i = 0; i < NUM_INST; i++) begin
                if (fc_all || i == INST_DIRECT ||
                    (i == INST_BMC && page_r == PAGE_BMC) ||
                    (i == INST_ME && page_r == PAGE_ME)) begin
                  clr_vec[i] = '1;
                end
              end
            end
            CMD_ALERT_MASK: begin
              // Low byte names the status register, high byte is mask
              if (hold_r.write) begin
                mask_nxt[inst] =
                  (mask_r[inst] & ~place(hold_r.wdata[7:0], 8'hff)) |
                  place(hold_r.wdata[7:0], hold_r.wdata[15:8]);
              end
              rd_exec_nxt = {8'h00, pick(mask_r[inst], hold_r.wdata[7:0])};
            end
            CMD_STAT_WORD: begin
              // Read only: it follows the lower registers
              ref_exec_nxt = hold_r.write;
              cml_set[1]   = hold_r.write;
              rd_exec_nxt  = summary(stat_r[inst], stat_r[INST_DIRECT].fan,
                                     output_on);
            end
            CMD_STAT_VOUT, CMD_STAT_FAN: begin
              // Single instance registers refuse paged access
              if (hold_r.paged) begin
                ref_exec_nxt = 1'b1;
                cml_set[1]   = 1'b1;
              end else begin
                if (hold_r.write) begin
                  clr_vec[INST_DIRECT] =
                    place(hold_r.cmd, hold_r.wdata[7:0]);
                end
                rd_exec_nxt = {8'h00, pick(stat_r[INST_DIRECT], hold_r.cmd)};
              end
            end
            CMD_STAT_IOUT, CMD_STAT_INPUT, CMD_STAT_TEMP, CMD_STAT_CML: begin
              if (hold_r.write) begin
                // Only the addressed copy clears
                clr_vec[inst] = place(hold_r.cmd, hold_r.wdata[7:0]);
              end
              rd_exec_nxt = {8'h00, pick(stat_r[inst], hold_r.cmd)};
            end
            CMD_TEMP_INLET, CMD_TEMP_RECT, CMD_TEMP_PFC: begin
              temp_cmd_nxt = 1'b1;
              ref_exec_nxt = hold_r.write;
              cml_set[1]   = hold_r.write;
            end
            default: begin
              ref_exec_nxt = 1'b1;
              cml_set[2]   = 1'b1;
            end
          endcase
        end
      end
      ST_REPLY: begin
        // Park the reply and toggle in the same cycle; the link syncs the toggle, so it sees the reply stable
        rep_nxt.rdata   = temp_cmd_r ? temp_rd : rd_exec_r;
        rep_nxt.refused = ref_exec_r;
        ack_nxt         = ~ack_tgl_r;
        state_nxt       = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Sticky status: a set in the clear cycle wins over the clear
  always_comb begin
    alert_any = 1'b0;
    for (int i = 0; i < NUM_INST; i++) begin
      stat_nxt[i] = (stat_r[i] & ~clr_vec[i]) | ev_stat;
      if (i != INST_DIRECT) begin
        stat_nxt[i].vout = 8'h00;
        stat_nxt[i].fan  = 8'h00;
      end
      alert_any = alert_any | (|(stat_r[i] & ~mask_r[i]));
    end
    // Latched faults in OFF_BITS of the direct copy and the pin both hold the output off
    on_nxt = op_r[OP_ON_BIT] && ctrl_q &&
             !(|(stat_r[INST_DIRECT] & OFF_BITS));
    keep_iout = stat_r[INST_DIRECT].iout & ~clr_vec[INST_DIRECT].iout;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r      <= ST_IDLE;
      page_r       <= PAGE_RST;
      op_r         <= OP_RST;
      rd_exec_r    <= '0;
      ref_exec_r   <= 1'b0;
      temp_cmd_r   <= 1'b0;
      reply_hold_r <= '0;
      ack_tgl_r    <= 1'b0;
      output_on    <= 1'b0;
      smbalert_out <= 1'b0;
      smbalert_oe  <= 1'b0;
      for (int i = 0; i < NUM_INST; i++) begin
        stat_r[i] <= '0;
        mask_r[i] <= (i == INST_ME) ? MASK_ME_RST : MASK_RST;
      end
    end else begin
      state_r      <= state_nxt;
      page_r       <= page_nxt;
      op_r         <= op_nxt;
      rd_exec_r    <= rd_exec_nxt;
      ref_exec_r   <= ref_exec_nxt;
      temp_cmd_r   <= temp_cmd_nxt;
      reply_hold_r <= rep_nxt;
      ack_tgl_r    <= ack_nxt;
      output_on    <= on_nxt;
      smbalert_out <= 1'b0;
      // Pulls the open-drain alert low while enabled
      smbalert_oe  <= alert_any;
      for (int i = 0; i < NUM_INST; i++) begin
        stat_r[i] <= stat_nxt[i];
        mask_r[i] <= mask_nxt[i];
      end
    end
  end

  // ---------------- Checks ----------------
  sticky_hold_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    1 |=> ((stat_r[INST_DIRECT].iout & $past(keep_iout)) == $past(keep_iout)))
    else $error("status bit dropped without a clear");
  shared_set_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    ev.ot_warn |=> stat_r[INST_BMC].temp[T_OTW] && stat_r[INST_ME].temp[T_OTW])
    else $error("event missed a paged instance");
  // The pin follows the unmasked status one clock later, both ways
  alert_follow_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    1 |=> smbalert_oe == $past(alert_any))
    else $error("alert does not track unmasked status");
  clear_all_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (fc_all && state_r == ST_EXEC && ev_stat == '0)
      |=> stat_r[INST_BMC] == '0 && stat_r[INST_ME] == '0)
    else $error("fault clear at page all left bits set");
  word_ro_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_r == ST_EXEC && hold_r.cmd == CMD_STAT_WORD && hold_r.write &&
     inst_ok && !hold_r.pec_err) |=> ##1 reply_hold_r.refused)
    else $error("summary word write not refused");
  op_off_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !op_r[OP_ON_BIT] |=> !output_on)
    else $error("output on while command bit is zero");
  ov_off_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    stat_r[INST_DIRECT].vout[VOUT_OV] |=> !output_on)
    else $error("output on during overvoltage fault");
  me_mask_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    $fell(arst_n) or $rose(arst_n) |-> !mask_r[INST_ME].iout[IOUT_OCW])
    else $error("engine mask default wrong");
  link_reply_a: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    link_take |-> ##[4:40] reply_valid)
    else $error("link transaction never answered");
  alert_seen_c: cover property (@(posedge clock) disable iff (!arst_n)
    $rose(smbalert_oe));
  clear_all_c: cover property (@(posedge clock) disable iff (!arst_n)
    fc_all && state_r == ST_EXEC);
  temp_read_c: cover property (@(posedge clock) disable iff (!arst_n)
    temp_cmd_r && state_r == ST_REPLY);
  paged_clr_c: cover property (@(posedge clock) disable iff (!arst_n)
    clr_vec[INST_ME] != '0 && !fc_all);
endmodule
`default_nettype wire

// File: host_link_model.sv
// Host controller model that issues transfers on the link clock
`default_nettype none
module host_link_model
  import psu_status_pkg::*;
(
  // Link request and reply
  input  wire logic                   link_clk,
  input  wire logic                   link_busy,
  input  wire logic                   reply_valid,
  input  wire psu_status_pkg::reply_s reply,
  output var  logic                   xact_valid,
  output var  psu_status_pkg::xact_s  xact
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    xact_valid = 1'b0;
    xact       = '0;
  end
  // One transfer, held until the link takes it, returning at the edge that shows the reply
  task automatic run(input xact_s x, output reply_s r, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge link_clk);
    xact_valid <= 1'b1;
    xact       <= x;
    // Hold the request through the edge that finds the link free; a
    // request still up when busy falls would be taken a second time
    do @(posedge link_clk); while (link_busy);
    xact_valid <= 1'b0;
    // Released fields carry junk so stale values cannot pass
    xact       <= ~x;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge link_clk);
      ok = reply_valid;
    end
    r = reply;
  endtask
endmodule
`default_nettype wire

// File: psu_status_alert_bank_bench.sv
// Self-checking bench for the supply status and alert bank
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module psu_status_alert_bank_bench import psu_status_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, link_clk = 0, arst_n = 0, ctrl_pin = 1;
  logic        xact_valid, link_busy, reply_valid;
  logic        output_on, smbalert_out, smbalert_oe;
  logic        temp_wr_valid = 0;
  logic [1:0]  temp_wr_sel = 0;
  logic [15:0] temp_wr_value = 0;
  logic [0:0]  fan_fault = 0, fan_warn = 0;
  event_s      events = '0;
  xact_s       xact;
  reply_s      reply, rd;
  int          n_fail = 0, n_checks = 0;
  // Core clock and an unrelated slower link clock
  initial forever #4 clock = ~clock;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  psu_status_alert_bank i_psu_status_alert_bank (
    .clock(clock), .arst_n(arst_n), .link_clk(link_clk),
    .xact_valid(xact_valid), .xact(xact), .link_busy(link_busy),
    .reply_valid(reply_valid), .reply(reply), .events(events),
    .fan_fault(fan_fault), .fan_warn(fan_warn), .ctrl_pin(ctrl_pin),
    .temp_wr_valid(temp_wr_valid), .temp_wr_sel(temp_wr_sel),
    .temp_wr_value(temp_wr_value), .output_on(output_on),
    .smbalert_out(smbalert_out), .smbalert_oe(smbalert_oe));
  host_link_model i_host_link_model (
    .link_clk(link_clk), .link_busy(link_busy),
    .reply_valid(reply_valid), .reply(reply),
    .xact_valid(xact_valid), .xact(xact));
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Transfer; reads compare data, writes compare the refusal flag
  task automatic t(input logic [7:0] c, input logic [7:0] pg,
                   input logic p, input logic w, input logic [15:0] d,
                   input logic [15:0] e);
    logic ok;
    i_host_link_model.run('{c, p, pg, w, d, 1'b0}, rd, ok);
    `CHK(ok, 1'b1)
    `CHK(link_busy, 1'b0)
    if (!w) `CHK(rd.rdata, e)
    else `CHK(rd.refused, e[0])
  endtask
  // Short event pulse, then let the synchronisers settle
  task automatic ev(input logic [12:0] e, input logic f);
    @(posedge clock);
    events    <= e;
    fan_fault <= f;
    repeat (3) @(posedge clock);
    events    <= '0;
    fan_fault <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  // Watchdog, well beyond the expected run of a few thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    repeat (10) @(posedge clock);
    `CHK(output_on, 1'b1)
    t(CMD_OUTPUT_ON_COMMAND, 0, 0, 0, 0, 16'h0080);
    t(CMD_ALERT_MASK, PAGE_ME, 1, 0, 16'h007b, 16'h00df);
    t(CMD_ALERT_MASK, PAGE_ME, 1, 0, 16'h007c, 16'h00ef);
    t(CMD_ALERT_MASK, PAGE_BMC, 1, 0, 16'h007d, 16'h00ff);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      temp_wr_valid <= 1'b1;
      temp_wr_sel   <= 2'(i);
      temp_wr_value <= 16'h1230 + 16'(i);
    end
    @(posedge clock);
    temp_wr_valid <= 1'b0;
    for (int i = 0; i < 3; i++)
      t(CMD_TEMP_INLET + 8'(i), 0, 0, 0, 0, 16'h1230 + 16'(i));
    t(CMD_STAT_WORD, 0, 0, 1, 16'hffff, 16'h0001);
    t(CMD_STAT_CML, PAGE_ME, 1, 0, 0, 16'h0040);
    // Overtemperature warning: sticky, shared, engine alert unmasked
    ev(13'h0001, 1'b0);
    t(CMD_STAT_TEMP, 0, 0, 0, 0, 16'h0040);
    t(CMD_STAT_WORD, PAGE_ME, 1, 0, 0, 16'h0006);
    `CHK(smbalert_oe, 1'b1)
    `CHK(smbalert_out, 1'b0)
    t(CMD_STAT_TEMP, 0, 0, 1, 16'h0000, 0);
    t(CMD_STAT_TEMP, 0, 0, 0, 0, 16'h0040);
    t(CMD_STAT_TEMP, 0, 0, 1, 16'h0040, 0);
    t(CMD_STAT_TEMP, 0, 0, 0, 0, 16'h0000);
    t(CMD_STAT_TEMP, PAGE_BMC, 1, 0, 0, 16'h0040);
    t(CMD_STAT_TEMP, PAGE_ME, 1, 1, 16'h0040, 0);
    `CHK(smbalert_oe, 1'b0)
    // Unmask the direct copy, then off-faults and a brief dropout
    t(CMD_ALERT_MASK, 0, 0, 1, 16'hbf7d, 0);
    ev(13'h1021, 1'b0);
    `CHK(smbalert_oe, 1'b1)
    `CHK(output_on, 1'b0)
    t(CMD_STAT_VOUT, 0, 0, 0, 0, 16'h0080);
    t(CMD_STAT_INPUT, 0, 0, 0, 0, 16'h0010);
    t(CMD_STAT_WORD, 0, 0, 0, 0, 16'ha04e);
    // Page FFh fault clear empties every instance
    t(CMD_PAGE, 0, 0, 1, 16'h00ff, 0);
    t(CMD_FAULT_CLEAR, 0, 0, 1, 0, 0);
    `CHK(smbalert_oe, 1'b0)
    t(CMD_STAT_TEMP, PAGE_BMC, 1, 0, 0, 16'h0000);
    t(CMD_STAT_INPUT, PAGE_ME, 1, 0, 0, 16'h0000);
    t(CMD_STAT_WORD, 0, 0, 0, 0, 16'h0000);
    // Output command bit and control pin
    t(CMD_OUTPUT_ON_COMMAND, 0, 0, 1, 16'h0000, 0);
    repeat (8) @(posedge clock);
    `CHK(output_on, 1'b0)
    t(CMD_OUTPUT_ON_COMMAND, 0, 0, 1, 16'h0080, 0);
    repeat (8) @(posedge clock);
    `CHK(output_on, 1'b1)
    ctrl_pin <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK(output_on, 1'b0)
    ctrl_pin <= 1'b1;
    // Fan fault: single direct instance, byte read and clear
    ev(13'h0000, 1'b1);
    t(CMD_STAT_FAN, 0, 0, 0, 0, 16'h0080);
    `CHK(output_on, 1'b0)
    t(CMD_STAT_FAN, PAGE_BMC, 1, 1, 16'h0080, 1);
    t(CMD_STAT_FAN, 0, 0, 1, 16'h0080, 0);
    repeat (8) @(posedge clock);
    `CHK(output_on, 1'b1)
    report_and_stop;
  end
endmodule
`default_nettype wire
